// file: hdl/split_desc.sv
// Purpose: Holds one interrupt transfer descriptor and runs its polling,
//          token and split sequence toward the USB side.
// Assumes: All inputs come from logic on clk_i; uframe_tick_i pulses once
//          per 125 us microframe.
// Notes: One descriptor; status bits raise a level interrupt.
//
// Overview of operation
// - Split flag 0: plain transaction; 1: start split then complete split.
// - Endpoint kind must be interrupt; token 00 sends OUT, 01 sends IN.
// - Seven-bit function id is the address of every token.
// - Endpoint number: three high bits from upper word, low bit from lower.
// - Each packet is capped at max payload; split endpoints allow 64 bytes.
// - Transfer length gives total bytes; total must stay within 4 kB.
// - Active flag clears after the whole descriptor or on a fatal error.
// - Speed code 10 addresses low-speed, 00 full-speed, for splits.
// - Rate field b gives a period of two to b minus one microframes.
// - Splits carry the hub id and hub port index from the descriptor.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module split_desc
    import split_desc_pkg::*;
#(
    parameter int UF_CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // USB transaction side
    input wire logic uframe_tick_i,
    output token_t tok_o,
    output logic tok_valid_o,
    input wire logic tok_ack_i,
    input wire logic xfer_done_i,
    input wire logic [10:0] xfer_bytes_i,
    input wire logic xfer_fatal_i,
    // Interrupt
    output logic irq_o
);
    if (UF_CNT_W < 8) begin : g_chk
        $error("UF_CNT_W too small for a 32 ms period");
    end

    // Period mask, b = highest set bit + 5; empty pattern means b = 4
    function automatic logic [7:0] poll_mask(input logic [4:0] rate);
        logic [7:0] m;
        m = 8'h07;
        if (rate[4]) begin
            m = 8'hff;
        end else if (rate[3]) begin
            m = 8'h7f;
        end else if (rate[2]) begin
            m = 8'h3f;
        end else if (rate[1]) begin
            m = 8'h1f;
        end else if (rate[0]) begin
            m = 8'h0f;
        end
        return m;
    endfunction

    logic [31:0] w0, w1, w2, w3;
    logic [1:0] status, irq_en;
    logic [14:0] remaining;
    logic [UF_CNT_W-1:0] uf_cnt;
    fsm_t state;

    // Decoded descriptor fields
    wire logic active = w0[ACTIVE_POS];
    wire logic [14:0] len_f = w0[LEN_POS +: 15];
    wire logic [10:0] mps_f = w0[MPS_POS +: 11];
    wire logic [3:0] ep_f = {w1[EP_HI_POS +: 3], w0[EP_LSB_POS]};
    wire logic [6:0] fid_f = w1[FID_POS +: 7];
    wire logic [1:0] token_f = w1[TOKEN_POS +: 2];
    wire logic [1:0] kind_f = w1[KIND_POS +: 2];
    wire logic split_f = w1[SPLIT_POS];
    wire logic [4:0] rate_f = w2[RATE_POS +: 5];
    wire logic [1:0] speed_f = w3[SPEED_POS +: 2];
    wire logic [6:0] port_f = w3[PORT_POS +: 7];
    wire logic [6:0] hub_f = w3[HUB_POS +: 7];

    // Register decode
    wire logic wr_w0 = wr_i && addr_i == OFF_W0;
    wire logic wr_w1 = wr_i && addr_i == OFF_W1;
    wire logic wr_w2 = wr_i && addr_i == OFF_W2;
    wire logic wr_w3 = wr_i && addr_i == OFF_W3;
    wire logic wr_en = wr_i && addr_i == OFF_IRQ_EN;
    wire logic wr_clr = wr_i && addr_i == OFF_IRQ_CLR;
    wire logic sw_set = wr_w0 && wdata_i[ACTIVE_POS];

    // Polling: a descriptor is due on a microframe matching its period
    wire logic [7:0] pmask = poll_mask(rate_f);
    wire logic poll_hit = uframe_tick_i &&
        ((uf_cnt[7:0] & pmask) == 8'h00);
    wire logic start = state == fsm_idle && active && poll_hit;

    // Oversized or wrong-kind descriptors are fatal, never run
    wire logic legal = kind_f == KIND_INTERRUPT &&
        (token_f == TOKEN_OUT || token_f == TOKEN_IN) &&
        len_f <= MAX_TOTAL &&
        (!split_f || mps_f <= FS_MAX_PAYLOAD);
    wire logic [10:0] pkt_len = ({4'h0, mps_f} < remaining) ?
        mps_f : remaining[10:0];
    wire logic in_wait = state == fsm_wait;
    wire logic sspl_done = in_wait && xfer_done_i && tok_o.split &&
        !tok_o.complete;
    wire logic data_done = in_wait && xfer_done_i && !sspl_done;
    wire logic [14:0] moved = {4'h0, xfer_bytes_i};
    wire logic [14:0] left = (moved >= remaining) ? 15'h0000 :
        15'(remaining - moved);
    // A short packet also ends the descriptor
    wire logic finish = data_done &&
        (left == 15'h0000 || xfer_bytes_i < tok_o.length);
    wire logic fatal = (start && !legal) || (in_wait && xfer_fatal_i);
    wire logic hw_clr = finish || fatal;
    wire logic [1:0] events = {fatal, finish};

    // Set wins over every clear
    wire logic next_active = sw_set ? 1'b1 :
        hw_clr ? 1'b0 :
        wr_w0 ? wdata_i[ACTIVE_POS] : active;
    wire logic [1:0] next_status = events |
        (wr_clr ? (status & ~wdata_i[1:0]) : status);
    wire logic [1:0] next_irq_en = wr_en ? wdata_i[1:0] : irq_en;

    wire logic [31:0] rd_mux =
        addr_i == OFF_W0 ? w0 :
        addr_i == OFF_W1 ? w1 :
        addr_i == OFF_W2 ? w2 :
        addr_i == OFF_W3 ? w3 :
        addr_i == OFF_STATUS ? {30'h0, status} :
        addr_i == OFF_IRQ_EN ? {30'h0, irq_en} :
        addr_i == OFF_PROGRESS ? {15'h0, tok_valid_o, 1'b0, remaining} :
        32'h0000_0000;

    // Descriptor words; reserved bits are dropped on write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            w0 <= REG_RESET;
            w1 <= REG_RESET;
            w2 <= REG_RESET;
            w3 <= REG_RESET;
        end else begin
            if (wr_w0) begin
                w0 <= wdata_i & W0_MASK;
            end
            w0[ACTIVE_POS] <= next_active;
            if (wr_w1) begin
                w1 <= wdata_i & W1_MASK;
            end
            if (wr_w2) begin
                w2 <= wdata_i & W2_MASK;
            end
            if (wr_w3) begin
                w3 <= wdata_i & W3_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            status <= EV_RESET;
            irq_en <= EV_RESET;
            irq_o <= 1'b0;
            rdata_o <= REG_RESET;
            uf_cnt <= '0;
        end else begin
            status <= next_status;
            irq_en <= next_irq_en;
            irq_o <= |(next_status & next_irq_en);
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
            uf_cnt <= uf_cnt + UF_CNT_W'(uframe_tick_i);
        end
    end

    // Remaining byte count; reloaded whenever software arms the descriptor
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            remaining <= 15'h0000;
        end else if (sw_set) begin
            remaining <= wdata_i[LEN_POS +: 15];
        end else if (data_done) begin
            remaining <= left;
        end
    end

    // Transaction sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= fsm_idle;
            tok_valid_o <= 1'b0;
            tok_o <= '0;
        end else begin
            case (state)
                fsm_idle: begin
                    if (start && legal) begin
                        tok_o.split <= split_f;
                        tok_o.complete <= 1'b0;
                        tok_o.is_in <= token_f == TOKEN_IN;
                        tok_o.function_id <= fid_f;
                        tok_o.endpoint_number <= ep_f;
                        tok_o.hub_id <= hub_f;
                        tok_o.hub_port_index <= port_f;
                        tok_o.speed_endpoint_code <= speed_f;
                        tok_o.length <= pkt_len;
                        tok_valid_o <= 1'b1;
                        state <= fsm_issue;
                    end
                end
                fsm_issue: begin
                    if (tok_ack_i) begin
                        tok_valid_o <= 1'b0;
                        state <= fsm_wait;
                    end
                end
                fsm_wait: begin
                    if (xfer_fatal_i) begin
                        state <= fsm_idle;
                    end else if (sspl_done) begin
                        tok_o.complete <= 1'b1;
                        tok_valid_o <= 1'b1;
                        state <= fsm_issue;
                    end else if (xfer_done_i) begin
                        state <= fsm_idle;
                    end
                end
                default: begin
                    state <= fsm_idle;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_split_start: assert property (
        $rose(tok_valid_o) && !tok_o.complete |-> tok_o.split == split_f)
        else $error("split flag not followed at issue");
    chk_token_dir: assert property (
        $rose(tok_valid_o) && !tok_o.complete |->
        tok_o.is_in == (token_f == TOKEN_IN) && kind_f == KIND_INTERRUPT)
        else $error("token direction or kind wrong");
    chk_func_addr: assert property (
        $rose(tok_valid_o) && !tok_o.complete |-> tok_o.function_id == fid_f)
        else $error("function id mismatch");
    chk_endpoint_join: assert property (
        $rose(tok_valid_o) && !tok_o.complete |->
        tok_o.endpoint_number == {w1[2:0], w0[31]})
        else $error("endpoint number mismatch");
    chk_payload_cap: assert property (
        tok_valid_o |-> tok_o.length <= mps_f &&
        (!tok_o.split || tok_o.length <= 11'h040))
        else $error("packet longer than max payload");
    chk_length_load: assert property (
        sw_set |=> remaining == $past(wdata_i[17:3]))
        else $error("transfer length not loaded");
    chk_fatal_clear: assert property (
        in_wait && xfer_fatal_i && !sw_set |=> !active ##1 !tok_valid_o)
        else $error("active not cleared on fatal error");
    chk_poll_period: assert property (
        state == fsm_idle && active && uframe_tick_i && rate_f == 5'h01 &&
        uf_cnt[3:0] != 4'h0 |=> !tok_valid_o)
        else $error("issued off the 2 ms period");
    chk_poll_gate: assert property (
        $rose(tok_valid_o) && !tok_o.complete |-> $past(poll_hit))
        else $error("token issued without a poll slot");
    chk_split_route: assert property (
        $rose(tok_valid_o) && tok_o.split && !tok_o.complete |->
        tok_o.hub_id == hub_f && tok_o.hub_port_index == port_f &&
        tok_o.speed_endpoint_code == speed_f)
        else $error("split routing fields mismatch");
    chk_csplit_follow: assert property (
        sspl_done && !xfer_fatal_i |=> tok_valid_o && tok_o.complete)
        else $error("complete split not issued");
    chk_done_clear: assert property (
        finish && !sw_set |=> !active && status[EV_DONE])
        else $error("active not cleared at descriptor end");
    chk_irq_level: assert property (
        irq_o == |(status & irq_en))
        else $error("interrupt level does not follow status");
    chk_reserved_drop: assert property (
        wr_w3 |=> w3 == ($past(wdata_i) & W3_MASK))
        else $error("reserved descriptor bits kept");

    cov_split_done: cover property (
        in_wait && tok_o.complete && finish);
    cov_plain_done: cover property (in_wait && !tok_o.split && finish);
    cov_fatal: cover property (fatal ##1 irq_o);
    // Short packet ending early is the path tests miss most easily
    cov_short_end: cover property (
        finish && left != 15'h0000);
endmodule

// file: inc/split_desc_pkg.sv
// Purpose: Shared constants and types for the interrupt split descriptor.
// Assumes: 32-bit register port, byte addresses on word boundaries.
// Notes: Descriptor words are held as four 32-bit registers.
package split_desc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_W0 = 8'h00;
    localparam logic [7:0] OFF_W1 = 8'h04;
    localparam logic [7:0] OFF_W2 = 8'h08;
    localparam logic [7:0] OFF_W3 = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_PROGRESS = 8'h1c;
    // Writable bits; reserved bits store and read as zero
    localparam logic [31:0] W0_MASK = 32'h9fff_fff9;
    localparam logic [31:0] W1_MASK = 32'h0000_7fff;
    localparam logic [31:0] W2_MASK = 32'h0000_00ff;
    localparam logic [31:0] W3_MASK = 32'hffff_0000;
    // Field positions inside their word
    localparam int ACTIVE_POS = 0;
    localparam int LEN_POS = 3;
    localparam int MPS_POS = 18;
    localparam int EP_LSB_POS = 31;
    localparam int EP_HI_POS = 0;
    localparam int FID_POS = 3;
    localparam int TOKEN_POS = 10;
    localparam int KIND_POS = 12;
    localparam int SPLIT_POS = 14;
    localparam int RATE_POS = 3;
    localparam int SPEED_POS = 16;
    localparam int PORT_POS = 18;
    localparam int HUB_POS = 25;
    // Encodings and limits
    localparam logic [1:0] KIND_INTERRUPT = 2'h3;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN = 2'h1;
    localparam logic [10:0] FS_MAX_PAYLOAD = 11'h040;
    localparam logic [14:0] MAX_TOTAL = 15'h1000;
    // Status bits and reset values
    localparam int EV_DONE = 0;
    localparam int EV_FATAL = 1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] EV_RESET = 2'h0;

    typedef enum {fsm_idle, fsm_issue, fsm_wait} fsm_t;

    typedef struct packed {
        logic split;
        logic complete;
        logic is_in;
        logic [6:0] function_id;
        logic [3:0] endpoint_number;
        logic [6:0] hub_id;
        logic [6:0] hub_port_index;
        logic [1:0] speed_endpoint_code;
        logic [10:0] length;
    } token_t;
endpackage

// file: verif/usb_far_end.sv
// Purpose: Behavioural hub translator and device on the token link.
// Assumes: One token in flight; replies only while valid is seen high.
// Notes: Reply speed, short packet and fatal reply are set by the bench.
`timescale 1ns/1ps
module usb_far_end
    import split_desc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Token link
    input wire token_t tok_i,
    input wire logic tok_valid_i,
    output logic tok_ack_o,
    output logic xfer_done_o,
    output logic [10:0] xfer_bytes_o,
    output logic xfer_fatal_o,
    // Bench controls
    input wire logic slow_i,
    input wire logic short_i,
    input wire logic fatal_i
);
    logic [10:0] plen;
    initial begin
        tok_ack_o = 1'b0;
        xfer_done_o = 1'b0;
        xfer_fatal_o = 1'b0;
        xfer_bytes_o = 11'h7ff;
    end
    // Start and complete split are each taken as their own token
    always begin
        @(posedge clk_i);
        if (rst_n_i && tok_valid_i) begin
            plen = tok_i.length;
            repeat (slow_i ? 3 : 0) @(posedge clk_i);
            tok_ack_o <= 1'b1;
            @(posedge clk_i);
            tok_ack_o <= 1'b0;
            repeat (slow_i ? 4 : 1) @(posedge clk_i);
            // Never more than the packet limit the token carried, except a short reply to a zero-length token, which wraps to 11'h7ff
            xfer_bytes_o <= short_i ? plen - 11'h1 : plen;
            xfer_done_o <= !fatal_i;
            xfer_fatal_o <= fatal_i;
            @(posedge clk_i);
            xfer_done_o <= 1'b0;
            xfer_fatal_o <= 1'b0;
            // Stale count must not look valid
            xfer_bytes_o <= ~xfer_bytes_o;
        end
    end
endmodule

// file: verif/testbench.sv
// Purpose: Self-checking bench for the interrupt split descriptor block.
// Assumes: Microframe tick every second cycle keeps poll slots short.
// Notes: Expected tokens and status come from an integer model.
`timescale 1ns/1ps
module testbench;
    import split_desc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic uframe_tick_i = 1'b0;
    logic slow = 1'b0;
    logic short_pk = 1'b0;
    logic fatal = 1'b0;
    logic prev_valid = 1'b0;
    logic [31:0] rdata_o, w;
    logic [31:0] seed = 32'hfa9b;
    token_t tok_o;
    logic tok_valid_o, tok_ack_i, xfer_done_i, xfer_fatal_i, irq_o;
    logic [10:0] xfer_bytes_i;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int last_rise = 0;
    int period = 0;
    int tok_seen = 0;
    int rates[6] = '{0, 1, 3, 4, 8, 16};
    logic [7:0] offs[5] = '{OFF_W1, OFF_W2, OFF_W3, 8'h20, OFF_IRQ_CLR};
    logic [31:0] masks[5] = '{W1_MASK, W2_MASK, W3_MASK, 32'h0, 32'h0};

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        uframe_tick_i <= ~uframe_tick_i;
        prev_valid <= tok_valid_o;
        if (tok_valid_o === 1'b1 && prev_valid !== 1'b1) begin
            tok_seen <= tok_seen + 1;
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    split_desc #(.UF_CNT_W(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .uframe_tick_i(uframe_tick_i), .tok_o(tok_o),
        .tok_valid_o(tok_valid_o), .tok_ack_i(tok_ack_i),
        .xfer_done_i(xfer_done_i), .xfer_bytes_i(xfer_bytes_i),
        .xfer_fatal_i(xfer_fatal_i), .irq_o(irq_o));
    usb_far_end u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .tok_i(tok_o),
        .tok_valid_i(tok_valid_o), .tok_ack_o(tok_ack_i),
        .xfer_done_o(xfer_done_i), .xfer_bytes_o(xfer_bytes_i),
        .xfer_fatal_o(xfer_fatal_i), .slow_i(slow), .short_i(short_pk),
        .fatal_i(fatal));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // Gap keeps back-to-back writes from re-driving the strobe
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    // Bounded wait on the token valid level, or on the active flag
    task automatic wait_for(input logic tok, input logic lvl);
        int n = 0;
        do begin
            if (tok) @(posedge clk_i);
            else rd(OFF_W0, w);
            n++;
        end while ((tok ? tok_valid_o : w[0]) !== lvl && n < 1200);
        if ((tok ? tok_valid_o : w[0]) !== lvl) begin
            check("wait bound", 1, 0);
            finish_test();
        end
    endtask
    task automatic run(input logic sp, input logic [1:0] tk, kd,
                       input int mps, len, rate, mode);
        logic [31:0] r, en, st, xs;
        token_t ex, sn;
        int rem, plen, npk, t0, msk, ntok;
        logic bad;
        r = rnd();
        en = {30'h0, r[28], ~r[28]};
        bad = kd != KIND_INTERRUPT || tk > 1 || len > 4096;
        bad = bad || (sp && mps > 64);
        msk = rate == 0 ? 7 : rate == 1 ? 15 : rate < 4 ? 31 : 0;
        msk = msk != 0 || rate < 4 ? msk : rate < 8 ? 63 : 0;
        msk = msk != 0 || rate < 8 ? msk : rate < 16 ? 127 : 255;
        ex = '0;
        ex.split = sp;
        ex.is_in = tk[0];
        ex.function_id = r[6:0];
        ex.endpoint_number = r[10:7];
        ex.hub_id = sp ? r[17:11] : 7'h0;
        ex.hub_port_index = sp ? r[24:18] : 7'h0;
        ex.speed_endpoint_code = {sp & r[25], 1'b0};
        slow <= r[26];
        short_pk <= mode == 1;
        fatal <= mode == 2;
        t0 = tok_seen;
        wr(OFF_IRQ_EN, en);
        rd(OFF_IRQ_EN, st);
        check("irq enable", st, en);
        wr(OFF_W3, {r[17:11], r[24:18], r[25], 1'b0, ~r[15:0]});
        wr(OFF_W2, {r[31:8], rate[4:0], 3'b000});
        wr(OFF_W1, {r[31:15], sp, kd, tk, r[6:0], r[10:8]});
        // Armed only once the whole descriptor is in place
        wr(OFF_W0, {r[7], r[30:29], mps[10:0], len[14:0], 2'b11, 1'b1});
        rem = len;
        npk = bad ? 0 : mode != 0 ? 1 : (len + mps - 1) / mps;
        for (int p = 0; p < npk; p++) begin
            plen = rem < mps ? rem : mps;
            ex.length = plen[10:0];
            for (int ph = 0; ph < (sp ? 2 : 1); ph++) begin
                wait_for(1'b1, 1'b1);
                sn = tok_o;
                ex.complete = ph[0];
                if (!sp) {sn.hub_id, sn.hub_port_index,
                          sn.speed_endpoint_code} = 16'h0;
                check("token", sn, ex);
                wait_for(1'b1, 1'b0);
                if (p == 1 && !sp) check("poll", period, 2 * msk + 2);
                if (mode == 2) break;
            end
            rem -= plen;
        end
        wait_for(1'b0, 1'b0);
        ntok = bad ? 0 : mode == 2 ? 1 : npk * (sp ? 2 : 1);
        check("tokens", tok_seen - t0, ntok);
        xs = (bad || mode == 2) ? 32'h2 : 32'h1;
        rd(OFF_STATUS, st);
        check("status", st, xs);
        check("irq", irq_o, |(xs & en));
        wr(OFF_IRQ_CLR, 32'h3);
        rd(OFF_STATUS, st);
        check("status clear", st, 0);
        check("irq clear", irq_o, 0);
        $display("run sp=%0d tk=%0d len=%0d mode=%0d end", sp, tk, len, mode);
    endtask

    initial begin
        logic [31:0] r;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a <= 32; a += 4) begin
            rd(a[7:0], w);
            check("reset value", w, REG_RESET);
        end
        foreach (offs[i]) wr(offs[i], 32'hffff_ffff);
        foreach (offs[i]) begin
            rd(offs[i], w);
            check("reserved bits", w, masks[i]);
        end
        foreach (offs[i]) wr(offs[i], 32'h0);
        $display("register test end");
        foreach (rates[i]) run(0, 2'(i % 2), 3, 8, 16, rates[i], 0);
        run(1, 1, 3, 64, 150, 0, 0);
        run(0, 0, 3, 1024, 4096, 0, 0);
        run(0, 1, 3, 16, 64, 0, 1);
        run(1, 0, 3, 8, 8, 0, 2);
        run(0, 0, 2, 8, 8, 0, 0);
        run(0, 2, 3, 8, 8, 0, 0);
        run(0, 1, 3, 8, 4097, 0, 0);
        run(1, 1, 3, 65, 65, 0, 0);
        repeat (4) begin
            r = rnd();
            run(r[0], {1'b0, r[1]}, 3, 8 + r[13:8] % 57, 1 + r[23:16],
                r[25:24], 0);
        end
        finish_test();
    end
endmodule
